// File: hw/ddsl_pkg.sv
// constants for the dual converter serial load logic
// assumes a single system clock mclk at 250 MHz and pin inputs from outside it
package ddsl_pkg;
  localparam int DDSL_FRAME_BITS = 18;
  localparam int DDSL_CODE_BITS = 16;
  localparam int DDSL_CHANNELS = 2;
  localparam int DDSL_ADDR_HI = 17;
  localparam int DDSL_ADDR_LO = 16;
  localparam logic [15:0] DDSL_MIDSCALE = 16'h8000;
  localparam logic [15:0] DDSL_ZEROSCALE = 16'h0000;
  localparam int DDSL_SYNC_STAGES = 2;
endpackage : ddsl_pkg

// File: hw/ddsl_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to mclk
`timescale 1ns/100ps
module ddsl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ddsl_sync

// File: hw/ddsl_top.sv
// serial load, input registers and converter registers of the dual converter
// assumes serial clock at most mclk/4 and pins asynchronous to mclk
`timescale 1ns/100ps
module ddsl_top
  import ddsl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic serial_in_line,
  input wire logic output_load_strobe,
  input wire logic preset_clear_n,
  input wire logic level_select,
  output logic [15:0] code_a,
  output logic [15:0] code_b,
  output logic [15:0] input_a,
  output logic [15:0] input_b,
  output logic serial_out_line
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pins_s;
  ddsl_sync #(.WIDTH(6)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({serial_clk, chip_sel_n, serial_in_line, output_load_strobe,
      preset_clear_n, level_select}),
    .sync_out(pins_s)
  );
  logic sclk_s, cs_n_s, sdi_s, ldst_s, preset_n_s, lvl_s;
  assign {sclk_s, cs_n_s, sdi_s, ldst_s, preset_n_s, lvl_s} = pins_s;

  logic sclk_d, cs_n_d;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end
  // ---------------------------------------------------------------
  // power-up preset
  // ---------------------------------------------------------------
  // synchronised pins read as reset values for the first edges;
  // select edge and preset are ignored until the pins have come through
  localparam logic [1:0] BOOT_LAST = 2'(DDSL_SYNC_STAGES);
  logic boot, boot_load;
  logic [1:0] boot_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      boot <= 1'b1;
      boot_cnt <= '0;
    end else if (boot) begin
      boot_cnt <= boot_cnt + 2'd1;
      if (boot_cnt == BOOT_LAST) begin
        boot <= 1'b0;
      end
    end
  end
  assign boot_load = boot && (boot_cnt == BOOT_LAST);

  logic sclk_rise, cs_rise, preset_on;
  assign sclk_rise = sclk_s && !sclk_d;
  assign cs_rise = cs_n_s && !cs_n_d && !boot;
  assign preset_on = !preset_n_s && !boot;

  logic [15:0] preset_code;
  assign preset_code = lvl_s ? DDSL_MIDSCALE : DDSL_ZEROSCALE;

  // ---------------------------------------------------------------
  // serial input register
  // ---------------------------------------------------------------
  logic [DDSL_FRAME_BITS-1:0] shift_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      shift_reg <= '0;
    end else if (sclk_rise && !cs_n_s) begin
      // new bit enters at the bottom, first bit ends at the top
      shift_reg <= {shift_reg[DDSL_FRAME_BITS-2:0], sdi_s};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      serial_out_line <= 1'b0;
    end else begin
      serial_out_line <= shift_reg[DDSL_FRAME_BITS-1];
    end
  end

  // ---------------------------------------------------------------
  // input and converter registers per channel
  // ---------------------------------------------------------------
  logic [DDSL_CHANNELS-1:0] hit;
  assign hit = {shift_reg[DDSL_ADDR_HI], shift_reg[DDSL_ADDR_LO]};
  logic [15:0] in_reg [DDSL_CHANNELS];
  logic [15:0] dac_reg [DDSL_CHANNELS];

  genvar ch;
  generate
    for (ch = 0; ch < DDSL_CHANNELS; ch++) begin : g_ch
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          in_reg[ch] <= DDSL_ZEROSCALE;
        end else if (boot_load) begin
          in_reg[ch] <= preset_code;
        end else if (preset_on) begin
          in_reg[ch] <= preset_code;
        end else if (cs_rise && hit[ch]) begin
          in_reg[ch] <= shift_reg[DDSL_CODE_BITS-1:0];
        end
      end
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          dac_reg[ch] <= DDSL_ZEROSCALE;
        end else if (boot_load) begin
          dac_reg[ch] <= preset_code;
        end else if (preset_on) begin
          dac_reg[ch] <= preset_code;
        end else if (!ldst_s) begin
          dac_reg[ch] <= in_reg[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      code_a <= DDSL_ZEROSCALE;
      code_b <= DDSL_ZEROSCALE;
      input_a <= DDSL_ZEROSCALE;
      input_b <= DDSL_ZEROSCALE;
    end else begin
      code_a <= dac_reg[0];
      code_b <= dac_reg[1];
      input_a <= in_reg[0];
      input_b <= in_reg[1];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_preset_forces: assert property (@(posedge mclk) disable iff (!rst_b)
    preset_on |=> (dac_reg[0] == $past(preset_code) && in_reg[1] == $past(preset_code)))
    else $error("preset did not force registers");
  a_preset_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    (preset_on && cs_rise) |=> in_reg[0] == $past(preset_code))
    else $error("serial load beat preset");
  a_shift_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    (sclk_rise && !cs_n_s) |=> shift_reg[0] == $past(sdi_s))
    else $error("bit not shifted in");
  a_shift_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs_n_s || !sclk_rise) |=> $stable(shift_reg))
    else $error("shift register moved while idle");
  a_msb_first: assert property (@(posedge mclk) disable iff (!rst_b)
    (sclk_rise && !cs_n_s) |=> shift_reg[1] == $past(shift_reg[0]))
    else $error("bit order wrong");
  a_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs_rise && !preset_on && shift_reg[DDSL_ADDR_LO])
      |=> in_reg[0] == $past(shift_reg[DDSL_CODE_BITS-1:0]))
    else $error("channel A not loaded");
  a_none_kept: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs_rise && !preset_on && !shift_reg[DDSL_ADDR_HI]) |=> $stable(in_reg[1]))
    else $error("channel B loaded without address");
  a_strobe_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (ldst_s && !preset_on && !boot_load) |=> ($stable(dac_reg[0]) && $stable(dac_reg[1])))
    else $error("converter register moved while held");
  a_strobe_follow: assert property (@(posedge mclk) disable iff (!rst_b)
    (!ldst_s && !preset_on && !boot_load) |=> (dac_reg[0] == $past(in_reg[0])
      && dac_reg[1] == $past(in_reg[1])))
    else $error("converter registers did not follow");

  // ---------------------------------------------------------------
  // checks on power-up and loading
  // ---------------------------------------------------------------
  a_boot_inputs: assert property (@(posedge mclk) disable iff (!rst_b)
    boot_load
      |=> (in_reg[0] == ($past(lvl_s) ? DDSL_MIDSCALE : DDSL_ZEROSCALE)
      && in_reg[1] == ($past(lvl_s) ? DDSL_MIDSCALE : DDSL_ZEROSCALE)))
    else $error("input registers missed power-up preset");
  a_boot_outputs: assert property (@(posedge mclk) disable iff (!rst_b)
    boot_load
      |=> (dac_reg[0] == ($past(lvl_s) ? DDSL_MIDSCALE : DDSL_ZEROSCALE)
      && dac_reg[1] == ($past(lvl_s) ? DDSL_MIDSCALE : DDSL_ZEROSCALE)))
    else $error("converter registers missed power-up preset");
  a_inputs_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    (!boot_load && !preset_on && !cs_rise)
      |=> ($stable(in_reg[0]) && $stable(in_reg[1])))
    else $error("input register moved without a load");
  a_load_b: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs_rise && !preset_on && shift_reg[DDSL_ADDR_HI])
      |=> in_reg[1] == $past(shift_reg[DDSL_CODE_BITS-1:0]))
    else $error("channel B not loaded");
  a_none_kept_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs_rise && !preset_on && !shift_reg[DDSL_ADDR_LO]) |=> $stable(in_reg[0]))
    else $error("channel A loaded without address");
  a_load_both: assert property (@(posedge mclk) disable iff (!rst_b)
    (cs_rise && !preset_on && shift_reg[DDSL_ADDR_HI] && shift_reg[DDSL_ADDR_LO])
      |=> in_reg[0] == in_reg[1])
    else $error("both channels not loaded alike");

  // ---------------------------------------------------------------
  // checks on preset values and outputs
  // ---------------------------------------------------------------
  a_preset_mid: assert property (@(posedge mclk) disable iff (!rst_b)
    (preset_on && lvl_s)
      |=> (in_reg[0] == DDSL_MIDSCALE && dac_reg[1] == DDSL_MIDSCALE))
    else $error("midscale preset value wrong");
  a_preset_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (preset_on && !lvl_s)
      |=> (in_reg[1] == DDSL_ZEROSCALE && dac_reg[0] == DDSL_ZEROSCALE))
    else $error("zero-scale preset value wrong");
  a_code_outputs: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
      |=> (code_a == $past(dac_reg[0]) && code_b == $past(dac_reg[1])))
    else $error("converter code outputs do not mirror registers");
  a_input_outputs: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
      |=> (input_a == $past(in_reg[0]) && input_b == $past(in_reg[1])))
    else $error("input code outputs do not mirror registers");
  a_serial_out: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> serial_out_line == $past(shift_reg[DDSL_FRAME_BITS-1]))
    else $error("serial out does not show top bit");
endmodule : ddsl_top

// File: testbench/ddsl_host.sv
// serial link host model for the dual converter load logic
// assumes the bench calls send between frames only
`timescale 1ns/100ps
module ddsl_host (
  output logic serial_clk,
  output logic chip_sel_n,
  output logic serial_in_line
);
  // link clock stands still low outside frames
  initial begin
    serial_clk = 1'b0;
    chip_sel_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // 18 bits, or 20 with two leading extra bits
  task automatic send(input logic [19:0] w, input logic extra);
    int n;
    n = extra ? 20 : 18;
    chip_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = w[i];
      #32 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
    end
    #32 chip_sel_n = 1'b1;
    // released data line shows no stale value
    serial_in_line = ~serial_in_line;
  endtask : send
endmodule : ddsl_host

// File: testbench/test_ddsl_top.sv
// self-checking bench for the dual converter serial load logic
// assumes ddsl_pkg, ddsl_top and ddsl_host are compiled first
`timescale 1ns/100ps
module test_ddsl_top;
  import ddsl_pkg::*;
  logic mclk, rst_b, serial_clk, chip_sel_n, serial_in_line, serial_out_line;
  logic output_load_strobe, preset_clear_n, level_select;
  logic [15:0] code_a, code_b, input_a, input_b, e_ia, e_ib, e_ca, e_cb, d;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  ddsl_host ddsl_host_inst (.serial_clk, .chip_sel_n, .serial_in_line);
  ddsl_top ddsl_top_inst (.mclk, .rst_b, .serial_clk, .chip_sel_n, .serial_in_line,
    .output_load_strobe, .preset_clear_n, .level_select, .code_a, .code_b, .input_a,
    .input_b, .serial_out_line);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %b want %b", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic check();
    repeat (16) @(posedge mclk);
    #1;
    cmp(input_a, e_ia);
    cmp(input_b, e_ib);
    cmp(code_a, e_ca);
    cmp(code_b, e_cb);
  endtask : check
  task automatic pins(input logic strobe, input logic pre_n, input logic lvl);
    @(posedge mclk);
    #1;
    output_load_strobe = strobe;
    preset_clear_n = pre_n;
    level_select = lvl;
  endtask : pins
  task automatic frame(input logic [19:0] w, input logic extra);
    @(posedge mclk);
    #1;
    ddsl_host_inst.send(w, extra);
    repeat (4) @(posedge mclk);
  endtask : frame
  initial begin
    rst_b = 1'b0;
    output_load_strobe = 1'b1;
    preset_clear_n = 1'b1;
    level_select = 1'b0;
    {e_ia, e_ib, e_ca, e_cb} = '0;
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    check();
    pins(1'b1, 1'b0, 1'b1);
    {e_ia, e_ib, e_ca, e_cb} = {4{DDSL_MIDSCALE}};
    check();
    pins(1'b1, 1'b0, 1'b0);
    {e_ia, e_ib, e_ca, e_cb} = {4{DDSL_ZEROSCALE}};
    check();
    pins(1'b1, 1'b1, 1'b0);
    // every address code, converter registers held
    for (int a = 0; a < 4; a++) begin
      d = 16'h1111 * 16'(a + 1);
      frame({2'b00, a[1:0], d}, 1'b0);
      if (a[0]) e_ia = d;
      if (a[1]) e_ib = d;
      check();
      cmp_bit(serial_out_line, a[1]);
    end
    pins(1'b0, 1'b1, 1'b0);
    e_ca = e_ia;
    e_cb = e_ib;
    check();
    frame({4'b1011, 16'h5a5a}, 1'b1);
    {e_ia, e_ib, e_ca, e_cb} = {4{16'h5a5a}};
    check();
    cmp_bit(serial_out_line, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    frame({4'b0001, 16'h0f0f}, 1'b0);
    {e_ia, e_ib, e_ca, e_cb} = {4{DDSL_MIDSCALE}};
    check();
    pins(1'b0, 1'b1, 1'b1);
    check();
    // second power-up with the level pin high
    pins(1'b1, 1'b1, 1'b1);
    rst_b = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    {e_ia, e_ib, e_ca, e_cb} = {4{DDSL_MIDSCALE}};
    check();
    pins(1'b0, 1'b1, 1'b1);
    check();
    frame({4'b0010, 16'hc3c3}, 1'b0);
    e_ib = 16'hc3c3;
    e_cb = 16'hc3c3;
    check();
    cmp_bit(serial_out_line, 1'b1);
    tally_and_finish();
  end
endmodule : test_ddsl_top
